/* File: core/epg_pkg.sv */
// Constants for the eight-pin general purpose port
package epg_pkg;
    localparam int unsigned PIN_COUNT = 8;
    localparam logic [11:0] PIN_LEVEL_OFFSET = 12'h434;
    localparam logic [11:0] PIN_SETUP_OFFSET = 12'h438;
    localparam int unsigned DIR_LSB = 0;
    localparam int unsigned KEEPER_LSB = 8;
    localparam int unsigned PULL_LSB = 16;
    localparam int unsigned OUT_LEVEL_LSB = 0;
    localparam int unsigned SENSE_LSB = 8;
    localparam logic [23:0] SETUP_RESET = 24'h000000;
    localparam logic [7:0] OUT_LEVEL_RESET = 8'h00;
    localparam int unsigned SYNC_STAGES = 2;
endpackage

/* File: core/epg_sync.sv */
// Two-flop synchroniser for the pin input levels
module epg_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Data
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] meta_q;
    logic [7:0] sync_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: core/epg_port.sv */
// Eight-pin general purpose port with setup and level registers
// Operation
// - Eight independent pins each have direction, keeper, pull, output and sense bits.
// - Setup bits 7:0 set direction, 0 input and 1 output.
// - Setup bits 15:8 pick keeper mode, 0 normal and 1 weak pull.
// - Setup bits 23:16 pick pull polarity, 0 down and 1 up.
// - A weak pull acts only when both keeper and direction bits of the pin are 1.
// - Level bits 7:0 hold driven levels and read back the last value written.
// - Level bits 15:8 are read-only sense bits showing each pin's synchronised level, output pins included.
// - Each level bit means 0 low and 1 high.
// - Reset clears the setup register and the low byte of the level register.
// - Both registers are reached through the configuration access port.
module epg_port (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration register access
    input wire logic [11:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_down_en
);
    logic [23:0] setup_q;
    logic [7:0] out_level_q;
    logic [31:0] rdata_q;
    logic [7:0] pin_out_q;
    logic [7:0] pin_oe_q;
    logic [7:0] pull_up_q;
    logic [7:0] pull_down_q;
    logic [7:0] sense;

    // Full-width compare, so no alias appears at a partial offset
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
        return addr == offset;
    endfunction

    wire logic [7:0] direction = setup_q[epg_pkg::DIR_LSB +: 8];
    wire logic [7:0] keeper_select = setup_q[epg_pkg::KEEPER_LSB +: 8];
    wire logic [7:0] pull_polarity = setup_q[epg_pkg::PULL_LSB +: 8];
    wire logic sel_level = reg_hit(cfg_addr, epg_pkg::PIN_LEVEL_OFFSET);
    wire logic sel_setup = reg_hit(cfg_addr, epg_pkg::PIN_SETUP_OFFSET);
    // Weak pull only on output pins in keeper mode
    wire logic [7:0] pull_active = keeper_select & direction;
    // Sense bits show the synchronised pin for every pin, output pins included, with no mux on the drive
    wire logic [7:0] sense_view = sense;
    wire logic [31:0] level_word = {16'h0000, sense_view, out_level_q};
    wire logic [31:0] setup_word = {8'h00, setup_q};
    wire logic [31:0] rdata_d = sel_level ? level_word :
                                sel_setup ? setup_word : 32'h0000_0000;

    epg_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(pin_in),
        .sync_out(sense)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_q <= epg_pkg::SETUP_RESET;
            out_level_q <= epg_pkg::OUT_LEVEL_RESET;
        end else begin
            if (cfg_wr && sel_setup) begin
                setup_q <= cfg_wdata[23:0];
            end
            // Sense bits in the write data are dropped
            if (cfg_wr && sel_level) begin
                out_level_q <= cfg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
            pin_out_q <= 8'h00;
            pin_oe_q <= 8'h00;
            pull_up_q <= 8'h00;
            pull_down_q <= 8'h00;
        end else begin
            rdata_q <= cfg_rd ? rdata_d : 32'h0000_0000;
            pin_out_q <= out_level_q;
            pin_oe_q <= direction;
            pull_up_q <= pull_active & pull_polarity;
            pull_down_q <= pull_active & ~pull_polarity;
        end
    end

    assign cfg_rdata = rdata_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign pull_up_en = pull_up_q;
    assign pull_down_en = pull_down_q;

    property p_setup_write;
        @(posedge clk) disable iff (!arst_n)
        cfg_wr && sel_setup |=> setup_q == $past(cfg_wdata[23:0]);
    endproperty
    a_setup_write: assert property (p_setup_write) else $error("setup write lost");

    property p_level_write;
        @(posedge clk) disable iff (!arst_n)
        cfg_wr && sel_level |=> out_level_q == $past(cfg_wdata[7:0]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write lost");

    property p_oe_follows;
        @(posedge clk) disable iff (!arst_n)
        cfg_wr && sel_setup |=> ##1 pin_oe == $past(cfg_wdata[7:0], 2);
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("direction not applied");

    property p_pull_gate;
        @(posedge clk) disable iff (!arst_n)
        ((pull_up_en | pull_down_en) & ~$past(pull_active)) == 8'h00;
    endproperty
    a_pull_gate: assert property (p_pull_gate) else $error("pull without keeper and output");

    property p_pull_excl;
        @(posedge clk) disable iff (!arst_n)
        (pull_up_en & pull_down_en) == 8'h00;
    endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");

    property p_pull_keeper;
        @(posedge clk) disable iff (!arst_n)
        (pull_up_en | pull_down_en) == $past(keeper_select & direction);
    endproperty
    a_pull_keeper: assert property (p_pull_keeper) else $error("keeper mode ignored");

    property p_sense_sync;
        @(posedge clk) disable iff (!arst_n)
        // Synchroniser is cleared by reset, so look only once it has run two edges
        $past(arst_n, 2) |-> sense == $past(pin_in, 2);
    endproperty
    a_sense_sync: assert property (p_sense_sync) else $error("sense not two flops");

    property p_read_level;
        @(posedge clk) disable iff (!arst_n)
        cfg_rd && sel_level |=> cfg_rdata == {16'h0000, $past(sense), $past(out_level_q)};
    endproperty
    a_read_level: assert property (p_read_level) else $error("level read wrong");

    property p_pin_level;
        @(posedge clk) disable iff (!arst_n)
        pin_out == $past(out_level_q);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

    property p_oe_copy;
        @(posedge clk) disable iff (!arst_n)
        pin_oe == $past(direction);
    endproperty
    a_oe_copy: assert property (p_oe_copy) else $error("enable not direction");

    property p_pull_up_val;
        @(posedge clk) disable iff (!arst_n)
        pull_up_en == $past(pull_active & pull_polarity);
    endproperty
    a_pull_up_val: assert property (p_pull_up_val) else $error("pull up wrong");

    property p_pull_down_val;
        @(posedge clk) disable iff (!arst_n)
        pull_down_en == $past(pull_active & ~pull_polarity);
    endproperty
    a_pull_down_val: assert property (p_pull_down_val) else $error("pull down wrong");

    property p_pull_output;
        @(posedge clk) disable iff (!arst_n)
        ((pull_up_en | pull_down_en) & ~pin_oe) == 8'h00;
    endproperty
    a_pull_output: assert property (p_pull_output) else $error("pull on input");

    property p_level_hold;
        @(posedge clk) disable iff (!arst_n)
        !(cfg_wr && sel_level) |=> $stable(out_level_q);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level changed");

    property p_setup_hold;
        @(posedge clk) disable iff (!arst_n)
        !(cfg_wr && sel_setup) |=> $stable(setup_q);
    endproperty
    a_setup_hold: assert property (p_setup_hold) else $error("setup changed");

    property p_read_setup;
        @(posedge clk) disable iff (!arst_n)
        cfg_rd && sel_setup |=> cfg_rdata == {8'h00, $past(setup_q)};
    endproperty
    a_read_setup: assert property (p_read_setup) else $error("setup read wrong");

    property p_read_idle;
        @(posedge clk) disable iff (!arst_n)
        !cfg_rd |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("idle data");

    // Reads off the map return zero rather than stale data
    property p_read_unmapped;
        @(posedge clk) disable iff (!arst_n)
        cfg_rd && !sel_level && !sel_setup |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("stray data");

    property p_upper_zero;
        @(posedge clk) disable iff (!arst_n)
        cfg_rdata[31:24] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    c_setup_write: cover property (@(posedge clk) disable iff (!arst_n) cfg_wr && sel_setup);
    c_level_read: cover property (@(posedge clk) disable iff (!arst_n) cfg_rd && sel_level);
    c_pull_up: cover property (@(posedge clk) disable iff (!arst_n) pull_up_en != 8'h00);
    c_pull_down: cover property (@(posedge clk) disable iff (!arst_n) pull_down_en != 8'h00);
    c_unmapped_read: cover property (@(posedge clk) disable iff (!arst_n)
        cfg_rd && !sel_level && !sel_setup);
endmodule

/* File: verification/epg_board.sv */
// Board model that closes the pins of the port
module epg_board (
    // Device side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Board drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pin with no driver at all shows the inverse of the last drive,
    // so a stale value cannot pass
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
        (~pin_oe & ~ext_en & ~pin_out);
endmodule

/* File: verification/eight_pin_gpio_port_bench.sv */
// Self-checking bench for the eight-pin port
module eight_pin_gpio_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] a = 12'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdat;
    logic [7:0] pin_in, po, oe, pu, pd;
    logic [7:0] ev = 8'h00;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] vals [2] = '{32'hffa5c3f0, 32'h0f5a3c0f};
    epg_port u_dut (.clk(clk), .arst_n(arst_n), .cfg_addr(a), .cfg_wr(wr), .cfg_rd(rd),
        .cfg_wdata(wd), .cfg_rdata(rdat), .pin_in(pin_in), .pin_out(po), .pin_oe(oe),
        .pull_up_en(pu), .pull_down_en(pd));
    epg_board u_board (.pin_out(po), .pin_oe(oe), .ext_val(ev), .ext_en(8'hff),
        .pin_in(pin_in));
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task wrt(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rdc(input logic [11:0] ad, input logic [31:0] e);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    task t_reset;
        chk({po, oe, pu, pd}, 32'h00000000);
        rdc(epg_pkg::PIN_SETUP_OFFSET, 32'h00000000);
        rdc(epg_pkg::PIN_LEVEL_OFFSET, 32'h00000000);
        $display("reset test done");
    endtask
    task t_setup;
        foreach (vals[i]) begin
            wrt(epg_pkg::PIN_SETUP_OFFSET, vals[i]);
            repeat (2) @(posedge clk);
            #1 chk({oe, pu, pd}, {vals[i][7:0], vals[i][15:8] & vals[i][7:0] & vals[i][23:16],
                vals[i][15:8] & vals[i][7:0] & ~vals[i][23:16]});
            rdc(epg_pkg::PIN_SETUP_OFFSET, vals[i] & 32'h00ffffff);
        end
        $display("setup test done");
    endtask
    task t_level;
        wrt(epg_pkg::PIN_SETUP_OFFSET, 32'h0000000f);
        ev <= 8'h35;
        // Only output bits carry ones; sense byte written to prove it is ignored
        wrt(epg_pkg::PIN_LEVEL_OFFSET, 32'hffffff0a);
        repeat (3) @(posedge clk);
        #1 chk({oe, po & oe}, 16'h0f0a);
        rdc(epg_pkg::PIN_LEVEL_OFFSET, 32'h00003a0a);
        $display("level test done");
    endtask
    task t_unmapped;
        wrt(12'h43c, 32'hffffffff);
        rdc(12'h43c, 32'h00000000);
        rdc(epg_pkg::PIN_SETUP_OFFSET, 32'h0000000f);
        $display("unmapped test done");
    endtask
    task t_rereset;
        wrt(epg_pkg::PIN_SETUP_OFFSET, 32'h00ff0fff);
        wrt(epg_pkg::PIN_LEVEL_OFFSET, 32'h000000a5);
        repeat (2) @(posedge clk);
        #1 chk({po, oe, pu, pd}, 32'ha5ff0f00);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({po, oe, pu, pd}, 32'h00000000);
        @(posedge clk);
        arst_n <= 1'b1;
        rdc(epg_pkg::PIN_SETUP_OFFSET, 32'h00000000);
        rdc(epg_pkg::PIN_LEVEL_OFFSET, 32'h00003500);
        $display("mid-run reset test done");
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_setup;
        t_level;
        t_unmapped;
        t_rereset;
        report_and_stop;
    end
endmodule
